// ### rtl/sas_pkg.sv
// shared constants for the converter sequencer
package sas_pkg;
   localparam int          RESULT_W          = 12;
   localparam int          CHAN_W            = 4;
   localparam logic [11:0] CTRL_ADDR         = 12'h0AD;
   localparam logic [11:0] RES_HIGH_ADDR     = 12'h0AF;
   localparam logic [11:0] RES_LOW_ADDR      = 12'h0AE;
   localparam logic [11:0] IRQ_EN_ADDR       = 12'h0B0;
   localparam logic [11:0] STATUS_ADDR       = 12'h0B4;
   localparam logic [11:0] MASK_ADDR         = 12'h0B8;
   localparam int          CTRL_POWER_BIT    = 7;
   localparam int          CTRL_TRIGGER_BIT  = 6;
   localparam int          CTRL_SLOW_BIT     = 5;
   localparam int          CTRL_DONE_BIT     = 4;
   localparam logic [7:0]  CTRL_RESET        = 8'h00;
   localparam logic [3:0]  CHAN_LAST_PIN     = 4'h9;
   localparam logic [3:0]  CHAN_QUARTER_SUPPLY = 4'hF;
   localparam int          CLK_HZ            = 40000000;
   localparam int          FAST_HZ           = 2000000;
   localparam int          SLOW_HZ           = 333000;
   localparam int          FAST_DIV          = CLK_HZ / FAST_HZ;
   localparam int          SLOW_DIV          = CLK_HZ / SLOW_HZ;
   localparam int          SAMPLE_PERIODS    = 6;
   localparam int          CONVERT_PERIODS   = 14;
   localparam int          DIV_W             = 8;
   localparam int          CNT_W             = 4;
   typedef enum logic [1:0] {SAS_IDLE, SAS_SAMPLE, SAS_CONVERT} sas_state_t;
endpackage : sas_pkg

// ### rtl/sas_core_if.sv
// link between sequencer and its tick divider
`timescale 1ns/1ps
interface sas_core_if;
   logic             run;
   logic [7:0]       divide;
   logic             tick;
   modport seq (output run, output divide, input tick);
   modport div (input run, input divide, output tick);
endinterface : sas_core_if

// ### rtl/sas_tick_div.sv
// clock-enable divider: one tick every divide cycles while run is high
`timescale 1ns/1ps
module sas_tick_div
   import sas_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   sas_core_if.div   link
);
   logic [DIV_W-1:0] cnt_ff;
   logic             tick_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff  <= '0;
         tick_ff <= 1'b0;
      end else if (!link.run) begin
         // preload one: the registered tick would otherwise stretch the first period by a cycle
         cnt_ff  <= DIV_W'(1);
         tick_ff <= 1'b0;
      end else if (cnt_ff == link.divide - 8'h01) begin
         cnt_ff  <= '0;
         tick_ff <= 1'b1;
      end else begin
         cnt_ff  <= cnt_ff + 8'h01;
         tick_ff <= 1'b0;
      end
   end
   assign link.tick = tick_ff;
endmodule : sas_tick_div

// ### rtl/sas_sequencer.sv
// converter control sequencer with apb register slave
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
// Notes on behaviour
// - produce a 12-bit result from the converter core over muxed pins
// - power bit: 0 turns converter power off, 1 on; resets to 0
// - writing 0 to trigger does nothing
// - slow select: sampling clock 2MHz when 0, 333kHz when 1
// - conversion clock stays 2MHz regardless of slow select
// - six sampling periods then fourteen conversion periods
// - trigger clears the done flag
// - finish sets done flag; it stays until changed
// - done flag is the interrupt request; only software clears it (irq here also comes from status masked by mask)
// - codes 0..9 pick pins, 1111 picks quarter supply node
// - result bits 11..4 in high byte, 3..0 in low byte upper nibble
// - done flag interrupts only while irq enable is 1
module sas_sequencer
   import sas_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   output logic                     converter_power_on,
   output logic [CHAN_W-1:0]        input_channel_select,
   output logic                     quarter_supply_select,
   output logic                     sample_hold,
   output logic                     convert_step,
   input  wire logic [RESULT_W-1:0] core_result,
   output logic                     irq
);
   sas_core_if link ();
   sas_state_t       state_ff;
   logic [CNT_W-1:0] period_ff;
   logic             power_ff;
   logic             slow_ff;
   logic             done_ff;
   logic [CHAN_W-1:0] chan_ff;
   logic [7:0]       res_high_ff;
   logic [3:0]       res_low_ff;
   logic             irq_en_ff;
   logic [1:0]       status_ff;
   logic [1:0]       mask_ff;
   logic [31:0]      prdata_ff;
   logic [RESULT_W-1:0] core_s1_ff;
   logic [RESULT_W-1:0] core_s2_ff;
   logic             wr;
   logic             rd;
   logic             trigger;
   logic             finish;
   logic             mapped;
   logic [31:0]      nxt_prdata;

   sas_tick_div u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .link    (link.div)
   );

   assign wr      = psel && penable && pwrite;
   assign rd      = psel && penable && !pwrite;
   assign pready  = 1'b1;
   assign mapped  = (paddr == CTRL_ADDR) || (paddr == RES_HIGH_ADDR) || (paddr == RES_LOW_ADDR) ||
                    (paddr == IRQ_EN_ADDR) || (paddr == STATUS_ADDR) || (paddr == MASK_ADDR);
   assign pslverr = psel && penable && !mapped;
   // a trigger written with the power bit at 0 is ignored: the core has no supply
   assign trigger = wr && (paddr == CTRL_ADDR) && pwdata[CTRL_TRIGGER_BIT] && pwdata[CTRL_POWER_BIT];
   assign finish  = (state_ff == SAS_CONVERT) && link.tick && (period_ff == CNT_W'(CONVERT_PERIODS - 1));

   // sampling divider follows slow select, conversion is always fast
   assign link.run    = (state_ff != SAS_IDLE);
   assign link.divide = (state_ff == SAS_SAMPLE && slow_ff) ? 8'(SLOW_DIV) : 8'(FAST_DIV);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff  <= SAS_IDLE;
         period_ff <= '0;
      end else begin
         case (state_ff)
            SAS_IDLE: begin
               period_ff <= '0;
               if (trigger) begin
                  state_ff <= SAS_SAMPLE;
               end
            end
            SAS_SAMPLE: begin
               if (!power_ff) begin
                  state_ff <= SAS_IDLE;
               end else if (link.tick) begin
                  if (period_ff == CNT_W'(SAMPLE_PERIODS - 1)) begin
                     period_ff <= '0;
                     state_ff  <= SAS_CONVERT;
                  end else begin
                     period_ff <= period_ff + 4'h1;
                  end
               end
            end
            SAS_CONVERT: begin
               if (!power_ff || finish) begin
                  state_ff <= SAS_IDLE;
               end else if (link.tick) begin
                  period_ff <= period_ff + 4'h1;
               end
            end
            default: begin
               state_ff <= SAS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_ff <= CTRL_RESET[CTRL_POWER_BIT];
         slow_ff  <= CTRL_RESET[CTRL_SLOW_BIT];
         chan_ff  <= CTRL_RESET[3:0];
      end else if (wr && paddr == CTRL_ADDR) begin
         power_ff <= pwdata[CTRL_POWER_BIT];
         slow_ff  <= pwdata[CTRL_SLOW_BIT];
         chan_ff  <= pwdata[3:0];
      end
   end

   // done flag: finish wins over any clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_ff <= 1'b0;
      end else if (finish) begin
         done_ff <= 1'b1;
      end else if (trigger) begin
         done_ff <= 1'b0;
      end else if (wr && paddr == CTRL_ADDR && !pwdata[CTRL_DONE_BIT]) begin
         done_ff <= 1'b0;
      end
   end

   // core result crosses in from analog side through two flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_s1_ff <= '0;
         core_s2_ff <= '0;
      end else begin
         core_s1_ff <= core_result;
         core_s2_ff <= core_s1_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         res_high_ff <= '0;
         res_low_ff  <= '0;
      end else if (finish) begin
         res_high_ff <= core_s2_ff[11:4];
         res_low_ff  <= core_s2_ff[3:0];
      end else if (wr && paddr == RES_HIGH_ADDR) begin
         res_high_ff <= pwdata[7:0];
      end else if (wr && paddr == RES_LOW_ADDR) begin
         res_low_ff  <= pwdata[7:4];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en_ff <= 1'b0;
         mask_ff   <= '0;
      end else if (wr && paddr == IRQ_EN_ADDR) begin
         irq_en_ff <= pwdata[0];
      end else if (wr && paddr == MASK_ADDR) begin
         mask_ff   <= pwdata[1:0];
      end
   end

   // status bit0 conversion finished, bit1 trigger accepted; write one clears, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_ff <= '0;
      end else begin
         status_ff[0] <= finish  | (status_ff[0] & ~(wr && paddr == STATUS_ADDR && pwdata[0]));
         status_ff[1] <= trigger | (status_ff[1] & ~(wr && paddr == STATUS_ADDR && pwdata[1]));
      end
   end

   always_comb begin
      nxt_prdata = 32'h0000_0000;
      case (paddr)
         CTRL_ADDR:     nxt_prdata[7:0] = {power_ff, 1'b0, slow_ff, done_ff, chan_ff};
         RES_HIGH_ADDR: nxt_prdata[7:0] = res_high_ff;
         RES_LOW_ADDR:  nxt_prdata[7:0] = {res_low_ff, 4'h0};
         IRQ_EN_ADDR:   nxt_prdata[0]   = irq_en_ff;
         STATUS_ADDR:   nxt_prdata[1:0] = status_ff;
         MASK_ADDR:     nxt_prdata[1:0] = mask_ff;
         default:       nxt_prdata      = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= nxt_prdata;
      end
   end
   assign prdata = rd ? prdata_ff : 32'h0000_0000;

   assign converter_power_on    = power_ff;
   assign input_channel_select  = chan_ff;
   assign quarter_supply_select = (chan_ff == CHAN_QUARTER_SUPPLY);
   assign sample_hold           = (state_ff == SAS_SAMPLE);
   assign convert_step          = (state_ff == SAS_CONVERT) && link.tick;
   // interrupt request from done flag under enable, or from masked status
   assign irq = (done_ff && irq_en_ff) || |(status_ff & mask_ff);
endmodule : sas_sequencer

// ### sim/sas_core_model.sv
// converter core stand-in: presents a held level while powered
`timescale 1ns/1ps
module sas_core_model
   import sas_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                power_on,
   input  wire logic [RESULT_W-1:0] level,
   output logic      [RESULT_W-1:0] result
);
   // unpowered output is untrustworthy, so it keeps toggling
   always_ff @(posedge pclk) begin
      result <= power_on ? level : ~result;
   end
endmodule : sas_core_model

// ### sim/sas_sequencer_properties.sv
// timing checks for the converter sequencer ports
`timescale 1ns/1ps
module sas_sequencer_properties
   import sas_pkg::*;
(
   input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic        converter_power_on, quarter_supply_select, sample_hold, convert_step, irq,
   input wire logic [3:0]  input_channel_select,
   input wire logic [11:0] core_result
);
   int   gap_ff, steps_ff, hold_ff;
   logic slow_ff;
   wire  wr = psel && penable && pwrite && paddr == CTRL_ADDR;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_ff   <= 0;
         steps_ff <= 0;
         hold_ff  <= 0;
         slow_ff  <= 1'b0;
      end else begin
         gap_ff   <= convert_step ? 1 : gap_ff + 1;
         steps_ff <= sample_hold ? 0 : steps_ff + int'(convert_step);
         hold_ff  <= sample_hold ? hold_ff + 1 : 0;
         slow_ff  <= wr ? pwdata[CTRL_SLOW_BIT] : slow_ff;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wr; psel && penable && pwrite && paddr == CTRL_ADDR; endsequence
   sequence s_start; s_wr ##0 pwdata[CTRL_POWER_BIT] && pwdata[CTRL_TRIGGER_BIT]; endsequence
   chk_power_write: assert property (s_wr |=> converter_power_on == $past(pwdata[7]))
      else $error("power bit not applied");
   chk_chan_write: assert property (s_wr |=> input_channel_select == $past(pwdata[3:0]))
      else $error("channel not applied");
   chk_quarter_sel: assert property (quarter_supply_select == (input_channel_select == 4'hF))
      else $error("quarter supply select wrong");
   chk_trig_start: assert property (s_start |=> sample_hold)
      else $error("trigger did not start sampling");
   chk_zero_trig: assert property (s_wr ##0 !pwdata[6] && !sample_hold |=> !sample_hold)
      else $error("zero trigger started sampling");
   chk_sample_len: assert property ($fell(sample_hold) |-> hold_ff == 6 * (slow_ff ? SLOW_DIV : FAST_DIV))
      else $error("sampling length wrong");
   chk_step_gap: assert property (convert_step && steps_ff != 0 |-> gap_ff == FAST_DIV)
      else $error("conversion step spacing wrong");
   chk_step_count: assert property (convert_step |-> steps_ff < CONVERT_PERIODS)
      else $error("too many conversion steps");
   chk_power_off: assert property ($fell(converter_power_on) |=> !sample_hold && !convert_step)
      else $error("activity after power off");
endmodule : sas_sequencer_properties
bind sas_sequencer sas_sequencer_properties u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
   .pslverr, .paddr, .pwdata, .prdata, .converter_power_on, .quarter_supply_select, .sample_hold,
   .convert_step, .irq, .input_channel_select, .core_result);

// ### sim/sas_sequencer_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module sas_sequencer_tb;
   import sas_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slv;
   logic [11:0] paddr = 12'h000, level = 12'h000, core_result;
   logic [31:0] pwdata = 32'h0, prdata, rd, lfsr = 32'h000123DB;
   logic        pready, pslverr, converter_power_on, quarter_supply_select, sample_hold, convert_step, irq;
   logic [3:0]  input_channel_select;
   int          err_count, n_tests, k, q[$];
   always #12.5 pclk = ~pclk;
   sas_sequencer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .converter_power_on, .input_channel_select, .quarter_supply_select, .sample_hold,
      .convert_step, .core_result, .irq);
   sas_core_model u_core (.pclk, .power_on(converter_power_on), .level, .result(core_result));
   function automatic logic [31:0] nxt_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : nxt_rand
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   // one apb transfer; waits for pready, then settles to the falling edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k >= 50) begin err_count++; wrap_up(); end
      rd = prdata; slv = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(negedge pclk);
   endtask : apb
   task automatic convert(input logic slow, input logic [3:0] ch);
      int exp_n;
      level <= lfsr[11:0]; q.push_back(int'(lfsr[11:0])); lfsr = nxt_rand(lfsr);
      exp_n = 6 * (slow ? SLOW_DIV : FAST_DIV) + 14 * FAST_DIV;
      // done bit written as 1 so only the trigger can clear it
      apb(1, CTRL_ADDR, {24'h0, 2'b11, slow, 1'b1, ch});
      apb(0, CTRL_ADDR, 0); `CHK(rd[7:0], {2'b10, slow, 1'b0, ch})
      // no control write until the flag sets; irq is looked at where it has settled
      for (k = 0; k < 2000 && irq !== 1'b1; k++) @(negedge pclk);
      `CHK(k <= exp_n && k + 8 >= exp_n, 1'b1)
      apb(0, RES_HIGH_ADDR, 0); `CHK(rd[7:0], 8'(q[0] >> 4))
      apb(0, RES_LOW_ADDR, 0); `CHK(rd[7:4], 4'(q.pop_front()))
      apb(0, CTRL_ADDR, 0); `CHK(rd[CTRL_DONE_BIT], 1'b1)
      $display("conversion slow=%0d done", slow);
   endtask : convert
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, CTRL_ADDR, 0); `CHK(rd, 32'h0)
      `CHK(prdata, 32'h0)
      apb(0, 12'h0C0, 0); `CHK({slv, rd}, {1'b1, 32'h0})
      apb(1, CTRL_ADDR, 32'h40); `CHK({converter_power_on, sample_hold}, 2'b00)
      for (int c = 0; c < 16; c++) if (c < 10 || c == 15) begin
         apb(1, CTRL_ADDR, 32'h80 | c); `CHK(input_channel_select, 4'(c))
         `CHK({quarter_supply_select, sample_hold}, {c == 15, 1'b0})
      end
      $display("channel select done");
      apb(1, IRQ_EN_ADDR, 1);
      convert(0, 4'h3);
      convert(1, 4'hF);
      repeat (50) @(posedge pclk);
      `CHK(irq, 1'b1)
      apb(1, IRQ_EN_ADDR, 0); `CHK(irq, 1'b0)
      apb(1, IRQ_EN_ADDR, 1); `CHK(irq, 1'b1)
      apb(1, CTRL_ADDR, 32'h80); `CHK(irq, 1'b0)
      apb(0, STATUS_ADDR, 0); `CHK(rd[1:0], 2'b11)
      apb(1, MASK_ADDR, 1); `CHK(irq, 1'b1)
      apb(1, STATUS_ADDR, 3); `CHK(irq, 1'b0)
      apb(1, CTRL_ADDR, 32'h00); `CHK(converter_power_on, 1'b0)
      $display("interrupt handling done");
      wrap_up();
   end
endmodule : sas_sequencer_tb
